/* core/pbg_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants for the port B block
package pbg_pkg;
    localparam int PBG_W = 8;
    // Register byte offsets
    localparam logic [11:0] OFF_PIN_LEVELS = 12'h000;
    localparam logic [11:0] OFF_OUT_LATCH = 12'h004;
    localparam logic [11:0] OFF_DIRECTION = 12'h008;
    localparam logic [11:0] OFF_PULLUP_EN = 12'h00C;
    localparam logic [11:0] OFF_INT_CTRL_TWO = 12'h010;
    localparam logic [11:0] OFF_SEG_SELECT = 12'h014;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
    // Field positions
    localparam int POS_GLOBAL_PU_DIS = 7;
    localparam int POS_EXT_EXTERNAL_INTERRUPT_ZERO = 0;
    localparam int POS_EDGE_LO = 2;
    localparam int POS_PROG_CLK = 6;
    localparam int POS_PROG_DAT = 7;
    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_EXTERNAL_INTERRUPT_ZERO = 0;
    localparam int IRQ_EDGE_ONE = 1;
    localparam int IRQ_EDGE_TWO = 2;
    // Reset values
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_PULLUP_EN = 8'h00;
    localparam logic [7:0] RST_INT_CTRL_TWO = 8'h80;
    localparam logic [7:0] RST_SEG_SELECT = 8'h00;
    localparam logic [1:0] RST_SYNC = 2'h0;
    localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

/* core/pbg_sync.sv */
`default_nettype none
// ============================================================
// Two-flop synchroniser for the pin levels
module pbg_sync
    import pbg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [PBG_W-1:0] din,
    output logic [PBG_W-1:0] dout
);
    logic [PBG_W-1:0] meta_ff;
    logic [PBG_W-1:0] sync_ff;
    logic [PBG_W-1:0] nxt_meta;
    logic [PBG_W-1:0] nxt_sync;

    // First stage read only by the second
    always_comb
    begin
        nxt_meta = din;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign dout = sync_ff;
endmodule // pbg_sync
`default_nettype wire

/* core/pbg_pad.sv */
`default_nettype none
// ============================================================
// One pin's drive, pull-up and input gating
module pbg_pad
(
    // Configuration
    input wire logic dir_in,
    input wire logic latch_bit,
    input wire logic pu_global_dis,
    input wire logic pu_en,
    input wire logic seg_sel,
    input wire logic seg_val,
    input wire logic ovr_en,
    input wire logic ovr_oe,
    input wire logic ovr_out,
    // Pad side
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pu,
    output logic dig_in_en
);
    logic seg_take;

    // Segment needs direction 0 to own the pin
    assign seg_take = seg_sel && !dir_in;
    // Override, then segment, then plain port drive
    always_comb
    begin
        if (ovr_en)
        begin
            pad_oe = ovr_oe;
            pad_out = ovr_out;
        end
        else if (seg_take)
        begin
            pad_oe = 1'b1;
            pad_out = seg_val;
        end
        else
        begin
            pad_oe = !dir_in;
            pad_out = latch_bit;
        end
    end
    // Pull-up off on any driving pin and when globally disabled
    assign pad_pu = !pu_global_dis && pu_en && !pad_oe && !seg_take;
    // No analog mode: only a segment blocks digital input
    assign dig_in_en = !seg_take;
endmodule // pbg_pad
`default_nettype wire

/* core/pbg_top.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
`default_nettype none
// ============================================================
// Summary of operation
// - Eight pins, each usable as a digital input or output.
// - Direction bit 0 drives the latch bit, 1 makes the pin an input.
// - There is no analog mode, so the digital input is never cut off by one.
// - A pull-up is on only with the global disable clear and its own enable set.
// - The global pull-up control gates all eight pins together.
// - Except pins 6 and 7 in programming mode, a pin configured as output has its pull-up forced off.
// - After power-on reset all pull-ups are off.
// - Pins 2 and 3 feed their level to the charge timer as edge inputs when inputs.
// - Except pins 6 and 7 in programming mode, a pin selected as display segment with direction 0 loses all other functions.
// - Programming functions override the direction bit.
// - Pin 0 as input delivers its level to external interrupt zero.
// - In programming mode pin 6 is the programming clock input.
// - In programming mode pin 7 is the programming data line, direction set there.
module pbg_top
    import pbg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [PBG_W-1:0] pin_in,
    output logic [PBG_W-1:0] pin_out,
    output logic [PBG_W-1:0] pin_oe,
    output logic [PBG_W-1:0] pin_pullup,
    // Display segment driver
    input wire logic [PBG_W-1:0] seg_value,
    // Programming port
    input wire logic prog_mode,
    input wire logic prog_data_oe,
    input wire logic prog_data_out,
    output logic program_clock,
    output logic program_data,
    // Peripheral taps
    output logic external_interrupt_zero,
    output logic charge_timer_edge_one,
    output logic charge_timer_edge_two,
    // Interrupt
    output logic irq
);
    // ========================================================
    // Register state
    logic [7:0] latch_ff, nxt_latch;
    logic [7:0] dir_ff, nxt_dir;
    logic [7:0] pu_en_ff, nxt_pu_en;
    logic [7:0] ctl2_ff, nxt_ctl2;
    logic [7:0] seg_ff, nxt_seg;
    logic [IRQ_W-1:0] stat_ff, nxt_stat;
    logic [IRQ_W-1:0] mask_ff, nxt_mask;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;
    logic ack_ff, nxt_ack;
    logic [PBG_W-1:0] lvl_sync;
    logic [PBG_W-1:0] dig_en;
    logic [PBG_W-1:0] pad_out_w, pad_oe_w, pad_pu_w;
    logic [PBG_W-1:0] in_lvl;
    logic [IRQ_W-1:0] tap_ff, nxt_tap;
    logic [IRQ_W-1:0] taps;
    logic [IRQ_W-1:0] evt;
    logic setup_ph, wr_acc;

    // Decoder used by both read and write paths
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        addr_hit = (a == off);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = addr_hit(a, OFF_PIN_LEVELS) || addr_hit(a, OFF_OUT_LATCH) ||
            addr_hit(a, OFF_DIRECTION) || addr_hit(a, OFF_PULLUP_EN) ||
            addr_hit(a, OFF_INT_CTRL_TWO) || addr_hit(a, OFF_SEG_SELECT) ||
            addr_hit(a, OFF_IRQ_STATUS) || addr_hit(a, OFF_IRQ_MASK);
    endfunction

    // ========================================================
    // Input synchroniser
    pbg_sync u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .din(pin_in),
        .dout(lvl_sync)
    );

    // ========================================================
    // Per-pin pad logic
    genvar gi;
    generate
        for (gi = 0; gi < PBG_W; gi++)
        begin : g_pad
            logic ovr_en_w, ovr_oe_w, ovr_out_w;
            // Programming pins ignore the direction bit
            assign ovr_en_w = prog_mode &&
                (gi == POS_PROG_CLK || gi == POS_PROG_DAT);
            assign ovr_oe_w = (gi == POS_PROG_DAT) ? prog_data_oe : 1'b0;
            assign ovr_out_w = (gi == POS_PROG_DAT) ? prog_data_out : 1'b0;
            pbg_pad u_pad
            (
                .dir_in(dir_ff[gi]),
                .latch_bit(latch_ff[gi]),
                .pu_global_dis(ctl2_ff[POS_GLOBAL_PU_DIS]),
                .pu_en(pu_en_ff[gi]),
                .seg_sel(seg_ff[gi]),
                .seg_val(seg_value[gi]),
                .ovr_en(ovr_en_w),
                .ovr_oe(ovr_oe_w),
                .ovr_out(ovr_out_w),
                .pad_out(pad_out_w[gi]),
                .pad_oe(pad_oe_w[gi]),
                .pad_pu(pad_pu_w[gi]),
                .dig_in_en(dig_en[gi])
            );
        end
    endgenerate

    // Pin drive for all eight bits
    assign pin_out = pad_out_w;
    assign pin_oe = pad_oe_w;
    assign pin_pullup = pad_pu_w;
    assign in_lvl = lvl_sync & dig_en;

    // ========================================================
    // Peripheral taps, only while the pin is an input
    assign external_interrupt_zero = in_lvl[POS_EXT_EXTERNAL_INTERRUPT_ZERO] && dir_ff[POS_EXT_EXTERNAL_INTERRUPT_ZERO];
    assign charge_timer_edge_one = in_lvl[POS_EDGE_LO] && dir_ff[POS_EDGE_LO];
    assign charge_timer_edge_two = in_lvl[POS_EDGE_LO+1] && dir_ff[POS_EDGE_LO+1];
    // Clock and data ignore the direction bit in programming mode
    assign program_clock = prog_mode && lvl_sync[POS_PROG_CLK];
    assign program_data = prog_mode && lvl_sync[POS_PROG_DAT];

    // ========================================================
    // Rising-edge events on the taps
    assign taps = {charge_timer_edge_two, charge_timer_edge_one, external_interrupt_zero};
    assign evt = taps & ~tap_ff;

    // ========================================================
    // APB access decode; one wait-free cycle, answer in access phase
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite && !err_ff;

    // Next register values
    always_comb
    begin
        nxt_latch = latch_ff;
        nxt_dir = dir_ff;
        nxt_pu_en = pu_en_ff;
        nxt_ctl2 = ctl2_ff;
        nxt_seg = seg_ff;
        nxt_mask = mask_ff;
        nxt_tap = taps;
        nxt_stat = stat_ff;
        if (wr_acc)
        begin
            // Either port register writes the latch
            if (addr_hit(paddr, OFF_PIN_LEVELS) || addr_hit(paddr, OFF_OUT_LATCH))
                nxt_latch = pwdata[7:0];
            if (addr_hit(paddr, OFF_DIRECTION))
                nxt_dir = pwdata[7:0];
            if (addr_hit(paddr, OFF_PULLUP_EN))
                nxt_pu_en = pwdata[7:0];
            if (addr_hit(paddr, OFF_INT_CTRL_TWO))
                nxt_ctl2 = pwdata[7:0];
            if (addr_hit(paddr, OFF_SEG_SELECT))
                nxt_seg = pwdata[7:0];
            if (addr_hit(paddr, OFF_IRQ_MASK))
                nxt_mask = pwdata[IRQ_W-1:0];
            if (addr_hit(paddr, OFF_IRQ_STATUS))
                nxt_stat = stat_ff & ~pwdata[IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        nxt_stat = nxt_stat | evt;
    end

    // Read data and slave error, captured in setup cycle
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        nxt_ack = setup_ph;
        if (setup_ph)
        begin
            nxt_err = !addr_mapped(paddr);
            if (addr_hit(paddr, OFF_PIN_LEVELS))
                nxt_rdata[7:0] = in_lvl;
            else if (addr_hit(paddr, OFF_OUT_LATCH))
                nxt_rdata[7:0] = latch_ff;
            else if (addr_hit(paddr, OFF_DIRECTION))
                nxt_rdata[7:0] = dir_ff;
            else if (addr_hit(paddr, OFF_PULLUP_EN))
                nxt_rdata[7:0] = pu_en_ff;
            else if (addr_hit(paddr, OFF_INT_CTRL_TWO))
                nxt_rdata[7:0] = ctl2_ff;
            else if (addr_hit(paddr, OFF_SEG_SELECT))
                nxt_rdata[7:0] = seg_ff;
            else if (addr_hit(paddr, OFF_IRQ_STATUS))
                nxt_rdata[IRQ_W-1:0] = stat_ff;
            else if (addr_hit(paddr, OFF_IRQ_MASK))
                nxt_rdata[IRQ_W-1:0] = mask_ff;
        end
        else
        begin
            nxt_rdata = rdata_ff;
            nxt_err = err_ff;
        end
    end

    // Registers; global disable set at reset keeps pull-ups off
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            latch_ff <= RST_LATCH;
            dir_ff <= RST_DIRECTION;
            pu_en_ff <= RST_PULLUP_EN;
            ctl2_ff <= RST_INT_CTRL_TWO;
            seg_ff <= RST_SEG_SELECT;
            stat_ff <= '0;
            mask_ff <= '0;
            tap_ff <= '0;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
            ack_ff <= 1'b0;
        end
        else
        begin
            latch_ff <= nxt_latch;
            dir_ff <= nxt_dir;
            pu_en_ff <= nxt_pu_en;
            ctl2_ff <= nxt_ctl2;
            seg_ff <= nxt_seg;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            tap_ff <= nxt_tap;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
            ack_ff <= nxt_ack;
        end
    end

    // Answer on the first access cycle, never waits longer
    assign pready = ack_ff;
    assign prdata = rdata_ff;
    assign pslverr = err_ff && psel && penable;
    assign irq = |(stat_ff & mask_ff);

    // ========================================================
    // Assertions
    a_pullup_off_output: assert property (@(posedge clk) disable iff (!rst_n)
        !prog_mode |-> ((pin_pullup & ~dir_ff) == 8'h00))
        else $error("pull-up on an output pin");
    a_pullup_global: assert property (@(posedge clk) disable iff (!rst_n)
        ctl2_ff[POS_GLOBAL_PU_DIS] |-> (pin_pullup == 8'h00))
        else $error("pull-up with global disable set");
    a_pullup_all_on: assert property (@(posedge clk) disable iff (!rst_n)
        (!ctl2_ff[POS_GLOBAL_PU_DIS] && dir_ff == 8'hFF && seg_ff == 8'h00
        && pu_en_ff == 8'hFF && !prog_mode) |-> (pin_pullup == 8'hFF))
        else $error("global enable did not reach every pin");
    a_pullup_reset: assert property (@(posedge clk)
        $rose(rst_n) |-> (pin_pullup == 8'h00))
        else $error("pull-up active after reset");
    a_drive_dir: assert property (@(posedge clk) disable iff (!rst_n)
        (!prog_mode && seg_ff == 8'h00) |-> (pin_oe == ~dir_ff && pin_out == latch_ff))
        else $error("pin drive does not follow direction");
    a_latch_write: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && pwrite && pready && !pslverr
        && (paddr == OFF_PIN_LEVELS || paddr == OFF_OUT_LATCH))
        |=> (latch_ff == $past(pwdata[7:0])))
        else $error("latch not updated by port write");
    a_seg_takeover: assert property (@(posedge clk) disable iff (!rst_n)
        (seg_ff[2] && !dir_ff[2]) |-> (pin_oe[2] && !charge_timer_edge_one
        && !pin_pullup[2]))
        else $error("segment pin kept other functions");

    // Level checks on the pin 0 and pin 2 taps look two cycles back, past the synchroniser, and skip a fresh reset
    a_external_interrupt_zero_tap: assert property (@(posedge clk) disable iff (!rst_n)
        (dir_ff[0] && $past(pin_in[0], 2) && $past(rst_n, 2) && $past(rst_n))
        |-> external_interrupt_zero)
        else $error("pin 0 level missing on interrupt tap");
    a_edge_one_tap: assert property (@(posedge clk) disable iff (!rst_n)
        (dir_ff[2] && $past(pin_in[2], 2) && $past(rst_n, 2) && $past(rst_n))
        |-> charge_timer_edge_one)
        else $error("pin 2 level missing on edge tap");
    a_edge_taps: assert property (@(posedge clk) disable iff (!rst_n)
        !dir_ff[3] |-> !charge_timer_edge_two)
        else $error("edge tap active on output pin");
    a_seg_value: assert property (@(posedge clk) disable iff (!rst_n)
        (seg_ff[3] && !dir_ff[3]) |-> (pin_oe[3] && pin_out[3] == seg_value[3]
        && !charge_timer_edge_two))
        else $error("segment pin not driven by segment value");

    // Programming pins
    a_prog_data: assert property (@(posedge clk) disable iff (!rst_n)
        prog_mode |-> (pin_oe[7] == prog_data_oe && pin_oe[6] == 1'b0))
        else $error("programming pins follow direction bit");
    a_prog_clock: assert property (@(posedge clk) disable iff (!rst_n)
        !prog_mode |-> !program_clock)
        else $error("programming clock outside programming mode");
    a_prog_clk_tap: assert property (@(posedge clk) disable iff (!rst_n)
        (prog_mode && $past(pin_in[POS_PROG_CLK], 2) && $past(rst_n, 2) && $past(rst_n))
        |-> program_clock)
        else $error("pin 6 level missing on programming clock");
    a_pu_prog_data: assert property (@(posedge clk) disable iff (!rst_n)
        (prog_mode && prog_data_oe) |-> !pin_pullup[POS_PROG_DAT])
        else $error("pull-up on driven programming data pin");

    // Register reads and the bus answer
    a_pin_read: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == OFF_PIN_LEVELS) |=> (prdata[7:0] == $past(in_lvl)))
        else $error("pin register read wrong");
    a_latch_read: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !pwrite && paddr == OFF_OUT_LATCH) |=> (prdata[7:0] == $past(latch_ff)))
        else $error("latch register read wrong");
    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
        setup_ph |=> pready)
        else $error("no answer in first access cycle");
    a_bus_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready held past one cycle");
    a_bus_refuse: assert property (@(posedge clk) disable iff (!rst_n)
        (setup_ph && !addr_mapped(paddr)) |=> (!penable || pslverr))
        else $error("unmapped access not refused");

    // Status bits: events stick, a clear with no event empties them
    a_irq_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (evt != 3'h0) |=> ((stat_ff & $past(evt)) == $past(evt)))
        else $error("event lost");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_acc && paddr == OFF_IRQ_STATUS && evt == 3'h0)
        |=> ((stat_ff & $past(pwdata[IRQ_W-1:0])) == 3'h0))
        else $error("status bit survived its clear");
    c_latch_write: cover property (@(posedge clk) disable iff (!rst_n)
        wr_acc && paddr == OFF_OUT_LATCH);
    c_pullup_on: cover property (@(posedge clk) disable iff (!rst_n) pin_pullup != 8'h00);
    c_prog_mode: cover property (@(posedge clk) disable iff (!rst_n) prog_mode && pin_oe[7]);
    c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
    c_seg_pin: cover property (@(posedge clk) disable iff (!rst_n) seg_ff[2] && !dir_ff[2]);
endmodule // pbg_top
`default_nettype wire

/* verification/pbg_pins_model.sv */
`default_nettype none
// ============================================================
// Far side: outside circuits hanging on the eight pins
module pbg_pins_model
(
    // Clock
    input wire logic clk,
    // Device side of the pads
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    // Outside drivers, commanded by the bench
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved wire levels
    output logic [7:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_ff;

    // Undriven lines show the opposite of their last level, never a lucky match
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_en[i])
                pin_level[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = ~last_ff[i];
        end
    end

    // Remember the last level that something really drove
    always @(posedge clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe[i] || ext_en[i] || pin_pullup[i])
                last_ff[i] <= pin_level[i];
        end
    end
endmodule // pbg_pins_model
`default_nettype wire

/* verification/port_b_gpio_with_pullups_tb.sv */
`default_nettype none
// ============================================================
// Register-level bench for the port B block
module port_b_gpio_with_pullups_tb;
    import pbg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] pin_level, pin_out, pin_oe, pin_pullup, seg_value, ext_en, ext_val;
    logic prog_mode, prog_data_oe, prog_data_out, program_clock, program_data;
    logic ext_external_interrupt_zero, edge_one, edge_two, irq;
    int miscompares, samples_checked, cycles;
    logic [11:0] offs [6] = '{OFF_OUT_LATCH, OFF_DIRECTION, OFF_PULLUP_EN,
        OFF_INT_CTRL_TWO, OFF_SEG_SELECT, OFF_IRQ_MASK};
    logic [7:0] rsts [6] = '{RST_LATCH, RST_DIRECTION, RST_PULLUP_EN,
        RST_INT_CTRL_TWO, RST_SEG_SELECT, 8'h00};

    pbg_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_level), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .seg_value(seg_value),
        .prog_mode(prog_mode), .prog_data_oe(prog_data_oe),
        .prog_data_out(prog_data_out), .program_clock(program_clock),
        .program_data(program_data), .external_interrupt_zero(ext_external_interrupt_zero),
        .charge_timer_edge_one(edge_one), .charge_timer_edge_two(edge_two), .irq(irq));
    pbg_pins_model FAR (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));

    // ============================================================
    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // ============================================================
    // Tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready, bounded
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Ready, data and error all taken at the one rising edge
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rd & {24'h0, m}, {24'h0, e});
    endtask
    // Synchroniser is two flops; leave margin, then look off the edge
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic drive(input logic [7:0] en, input logic [7:0] v);
        @(posedge clk);
        ext_en <= en;
        ext_val <= v;
    endtask

    // ============================================================
    // Main sequence
    initial
    begin
        {rst_n, psel, penable, pwrite, prog_mode, prog_data_oe, prog_data_out} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        seg_value = 8'h00;
        ext_en = 8'hFF;
        ext_val = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state
        for (int i = 0; i < 6; i++)
            rdchk(offs[i], 8'hFF, rsts[i]);
        rdchk(OFF_IRQ_STATUS, 8'hFF, 8'h00);
        chk(pin_pullup, 8'h00);
        chk(pin_oe, 8'h00);
        // Unmapped place: refused, write lost, reads zero
        apb(12'h020, 1'b1, 32'hFF);
        chk(err, 1'b1);
        apb(12'h020, 1'b0, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        // Outside drivers only on input pins
        drive(8'h0F, 8'h0A);
        wr(OFF_DIRECTION, 8'h0F);
        wr(OFF_OUT_LATCH, 8'hA5);
        settle();
        chk(pin_oe, 8'hF0);
        chk(pin_out & 8'hF0, 8'hA0);
        rdchk(OFF_PIN_LEVELS, 8'hFF, 8'hAA);
        rdchk(OFF_OUT_LATCH, 8'hFF, 8'hA5);
        wr(OFF_PIN_LEVELS, 8'h3C);
        settle();
        rdchk(OFF_OUT_LATCH, 8'hFF, 8'h3C);
        chk(pin_out & 8'hF0, 8'h30);
        // Pull-ups: global gate, per-pin enable, forced off on outputs
        wr(OFF_PULLUP_EN, 8'hFF);
        settle();
        chk(pin_pullup, 8'h00);
        wr(OFF_INT_CTRL_TWO, 8'h00);
        settle();
        chk(pin_pullup, 8'h0F);
        wr(OFF_PULLUP_EN, 8'h05);
        drive(8'h00, 8'h00);
        settle();
        chk(pin_pullup, 8'h05);
        rdchk(OFF_PIN_LEVELS, 8'h05, 8'h05);
        wr(OFF_INT_CTRL_TWO, 8'h80);
        settle();
        chk(pin_pullup, 8'h00);
        // Taps and interrupts
        wr(OFF_DIRECTION, 8'hFF);
        drive(8'hFF, 8'h00);
        wr(OFF_IRQ_STATUS, 8'h07);
        settle();
        rdchk(OFF_IRQ_STATUS, 8'hFF, 8'h00);
        drive(8'hFF, 8'h0D);
        settle();
        chk({edge_two, edge_one, ext_external_interrupt_zero, irq}, 4'hE);
        rdchk(OFF_IRQ_STATUS, 8'hFF, 8'h07);
        wr(OFF_IRQ_MASK, 8'h01);
        settle();
        chk(irq, 1'b1);
        wr(OFF_IRQ_STATUS, 8'h01);
        settle();
        chk(irq, 1'b0);
        rdchk(OFF_IRQ_STATUS, 8'hFF, 8'h06);
        wr(OFF_IRQ_MASK, 8'h06);
        settle();
        chk(irq, 1'b1);
        wr(OFF_IRQ_STATUS, 8'h06);
        settle();
        chk(irq, 1'b0);
        // Taps silent while those pins are outputs driving high
        wr(OFF_OUT_LATCH, 8'hFF);
        drive(8'hF2, 8'hF2);
        wr(OFF_DIRECTION, 8'hF2);
        settle();
        chk({edge_two, edge_one, ext_external_interrupt_zero, pin_level[0]}, 4'h1);
        // Segment pins 2 and 3
        @(posedge clk);
        seg_value <= 8'h08;
        wr(OFF_SEG_SELECT, 8'h0C);
        settle();
        chk(pin_out & 8'h0C, 8'h08);
        rdchk(OFF_PIN_LEVELS, 8'h0C, 8'h00);
        wr(OFF_SEG_SELECT, 8'h00);
        // Programming mode on pins 6 and 7
        @(posedge clk);
        {prog_mode, prog_data_oe, prog_data_out} <= 3'b110;
        ext_en <= 8'h40;
        ext_val <= 8'h40;
        wr(OFF_DIRECTION, 8'h00);
        settle();
        chk({pin_oe & 8'hC0, pin_out[7], program_clock}, 10'h201);
        drive(8'h40, 8'h00);
        settle();
        chk(program_clock, 1'b0);
        @(posedge clk);
        prog_data_oe <= 1'b0;
        ext_en <= 8'hC0;
        ext_val <= 8'h80;
        settle();
        chk({pin_oe & 8'hC0, program_data}, 9'h001);
        @(posedge clk);
        prog_mode <= 1'b0;
        ext_en <= 8'h00;
        settle();
        chk(pin_oe, 8'hFF);
        // Pull-ups on every input pin, then a reset in mid-run drops them all
        wr(OFF_DIRECTION, 8'hFF);
        wr(OFF_INT_CTRL_TWO, 8'h00);
        wr(OFF_PULLUP_EN, 8'hFF);
        settle();
        chk(pin_pullup, 8'hFF);
        rdchk(OFF_PIN_LEVELS, 8'hFF, 8'hFF);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(pin_pullup, 8'h00);
        rdchk(OFF_INT_CTRL_TWO, 8'hFF, 8'h80);
        rdchk(OFF_PULLUP_EN, 8'hFF, 8'h00);
        complete_run();
    end
endmodule // port_b_gpio_with_pullups_tb
`default_nettype wire
